// File: rtl/rcc_pkg.sv
// Constants for the reset-cause and run-clock configuration block
package rcc_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] OFS_CAUSE    = 12'h05C;
   localparam logic [11:0] OFS_CLKCFG   = 12'h060;
   localparam logic [11:0] OFS_IRQSTAT  = 12'h064;
   localparam logic [11:0] OFS_IRQMASK  = 12'h068;

   // ==========================================================
   // Reset-cause flag positions
   localparam int CAUSE_W              = 6;
   localparam int CAUSE_OUTSIDE_PIN    = 0;
   localparam int CAUSE_POWER_ON       = 1;
   localparam int CAUSE_BROWNOUT       = 2;
   localparam int CAUSE_WATCHDOG       = 3;
   localparam int CAUSE_SOFTWARE       = 4;
   localparam int CAUSE_REGULATOR_LOSS = 5;
   localparam logic [CAUSE_W-1:0] CAUSE_ONLY_PIN = 6'h01;

   // ==========================================================
   // Clock configuration field positions
   localparam int AUTO_GATING_BIT    = 27;
   localparam int SYSTEM_CLOCK_DIVISOR_LSB         = 23;
   localparam int SYSTEM_CLOCK_DIVISOR_W           = 4;
   localparam int SYSTEM_CLOCK_DIVISOR_EN_BIT      = 22;
   localparam int PWM_CLOCK_DIVISOR_EN_BIT      = 20;
   localparam int PWM_CLOCK_DIVISOR_LSB         = 17;
   localparam int PWM_CLOCK_DIVISOR_W           = 3;
   localparam int BYPASS_BIT         = 11;

   // ==========================================================
   // Clock configuration values after reset and limits
   localparam logic                AUTO_GATING_RST = 1'b0;
   localparam logic [SYSTEM_CLOCK_DIVISOR_W-1:0] SYSTEM_CLOCK_DIVISOR_RST      = 4'hF;
   localparam logic                SYSTEM_CLOCK_DIVISOR_EN_RST   = 1'b0;
   localparam logic                PWM_CLOCK_DIVISOR_EN_RST   = 1'b0;
   localparam logic [PWM_CLOCK_DIVISOR_W-1:0] PWM_CLOCK_DIVISOR_RST      = 3'h7;
   localparam logic                BYPASS_RST      = 1'b1;
   localparam logic [SYSTEM_CLOCK_DIVISOR_W-1:0] SYSTEM_CLOCK_DIVISOR_MIN_PLL  = 4'h3;
   localparam logic [SYSTEM_CLOCK_DIVISOR_W-1:0] SYSTEM_CLOCK_DIVISOR_RESERVED = 4'h0;
   localparam logic [PWM_CLOCK_DIVISOR_W-1:0] PWM_CLOCK_DIVISOR_TOP_CODE = 3'h5;

   // ==========================================================
   // Divider ratio widths
   localparam int SYS_RATIO_W = 5;
   localparam int PWM_RATIO_W = 7;

   // ==========================================================
   // Interrupt status bits
   localparam int IRQ_W            = 2;
   localparam int IRQ_RESERVED_DIV = 0;
   localparam int IRQ_FORCED_DIV   = 1;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

   // ==========================================================
   // Power modes
   typedef enum logic [2:0] {
      MODE_RUN   = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_DEEP  = 3'b100
   } power_mode_t;

endpackage

// File: rtl/div_if.sv
// Carrier between the configuration logic and a pulse divider
`timescale 1ns/1ps
interface div_if #(parameter int W = 5);
   logic         enable;
   logic         tick;
   logic [W-1:0] ratio;
   logic         pulse;

   modport ctrl (output enable, output tick, output ratio, input pulse);
   modport div  (input enable, input tick, input ratio, output pulse);
endinterface

// File: rtl/clk_pulse_div.sv
// Divider that turns input ticks into one-cycle enable pulses
`timescale 1ns/1ps
module clk_pulse_div #(
   parameter int W = 5
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   div_if.div        dv
);

   logic [W-1:0] count;

   // ==========================================================
   // Counting, or pass ticks through one cycle later when disabled
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         count    <= '0;
         dv.pulse <= 1'b0;
      end else if (!dv.enable) begin
         count    <= '0;
         dv.pulse <= dv.tick;
      end else if (dv.tick) begin
         if (count >= W'(dv.ratio - W'(1))) begin
            count    <= '0;
            dv.pulse <= 1'b1;
         end else begin
            count    <= W'(count + W'(1));
            dv.pulse <= 1'b0;
         end
      end else begin
         dv.pulse <= 1'b0;
      end
   end

endmodule

// File: rtl/reset_cause_clock_ctrl.sv
// Reset-cause flags and run-mode clock configuration with APB access
//
// Local design decision: the APB register port.
`timescale 1ns/1ps

// Contract
// - On reset the cause flags load from the cause of that reset, not a fixed value.
// - An outside-pin reset sets the pin flag and clears every other cause flag.
// - Any other reset keeps earlier flags so that causes accumulate.
// - Bit 0 marks the outside pin, bit 1 power-on and bit 2 brown-out.
// - Bit 3 marks watchdog, bit 4 software and bit 5 regulator power-good loss.
// - With auto gating set, sleep uses the sleep set and deep sleep the deep-sleep set.
// - With auto gating clear, sleep modes keep using the run gating set.
// - Run mode always uses the run gating set.
// - System divisor at bits 26:23 resets to 0xF; in bypass code n divides by n+1, 0 reserved.
// - With the PLL in use, codes below 0011 are reserved and the PLL output is divided.
// - Bit 22 selects the system divider, which is forced on in some configurations.
// - Bit 20 selects the PWM divider as PWM clock source, otherwise it is unused.
// - PWM divisor at bits 19:17 resets to 7 and divides by 2 to 32, or 64 for codes 5 to 7.
// - Bypass set clocks the system from the oscillator, clear from the divided PLL.
module reset_cause_clock_ctrl #(
   parameter int NPERIPH = 32
) (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire logic [11:0]         paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [5:0]          resetSource,
   input  wire logic                sleepReq,
   input  wire logic                deepSleepReq,
   input  wire logic [NPERIPH-1:0]  runGatingSet,
   input  wire logic [NPERIPH-1:0]  sleepGatingSet,
   input  wire logic [NPERIPH-1:0]  deepSleepGatingSet,
   output logic      [NPERIPH-1:0]  periphClkEn,
   output logic                     sysClkEn,
   output logic                     pwmClkEn,
   output logic                     sysSrcPll,
   output logic                     irq
);

   // ==========================================================
   // Declarations
   logic [rcc_pkg::CAUSE_W-1:0]     causeMeta;
   logic [rcc_pkg::CAUSE_W-1:0]     causeSync;
   logic [rcc_pkg::CAUSE_W-1:0]     resetCause;
   logic                            autoGating;
   logic [rcc_pkg::SYSTEM_CLOCK_DIVISOR_W-1:0]    sysDivisor;
   logic                            sysDivEnable;
   logic                            pwmDivEnable;
   logic [rcc_pkg::PWM_CLOCK_DIVISOR_W-1:0]    pwmDivisor;
   logic                            bypass;
   logic [rcc_pkg::IRQ_W-1:0]       irqStatus;
   logic [rcc_pkg::IRQ_W-1:0]       irqMask;
   logic [rcc_pkg::IRQ_W-1:0]       irqEvent;
   rcc_pkg::power_mode_t            powerMode;
   rcc_pkg::power_mode_t            next_powerMode;
   logic                            setupPhase;
   logic                            accessPhase;
   logic                            wrStrobe;
   logic                            mapped;
   logic [31:0]                     readValue;
   logic [31:0]                     clkCfgValue;
   logic [rcc_pkg::SYSTEM_CLOCK_DIVISOR_W-1:0]    effSysDiv;
   logic                            sysDivUsed;
   logic [rcc_pkg::PWM_CLOCK_DIVISOR_W-1:0]    pwmCode;
   logic [rcc_pkg::SYSTEM_CLOCK_DIVISOR_W-1:0]    wrSysDiv;
   logic                            wrBypass;
   logic                            wrSysDivEnable;

   div_if #(.W(rcc_pkg::SYS_RATIO_W)) system_clock_divisor ();
   div_if #(.W(rcc_pkg::PWM_RATIO_W)) pwm_clock_divisor ();

   // ==========================================================
   // Reset sources come from the reset controller, so resync them
   always_ff @(posedge clk_sys) begin
      causeMeta <= resetSource;
      causeSync <= causeMeta;
   end

   // ==========================================================
   // APB decode, zero wait states
   assign setupPhase  = psel && !penable;
   assign accessPhase = psel && penable;
   assign wrStrobe    = accessPhase && pwrite && mapped;
   assign pready      = accessPhase;
   assign pslverr     = accessPhase && !mapped;

   always_comb begin
      mapped = (paddr == rcc_pkg::OFS_CAUSE) || (paddr == rcc_pkg::OFS_CLKCFG) ||
               (paddr == rcc_pkg::OFS_IRQSTAT) || (paddr == rcc_pkg::OFS_IRQMASK);
   end

   // ==========================================================
   // Cause flags: loaded by reset, writable otherwise
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         if (causeSync[rcc_pkg::CAUSE_OUTSIDE_PIN]) begin
            resetCause <= rcc_pkg::CAUSE_ONLY_PIN;
         end else begin
            resetCause <= resetCause | causeSync;
         end
      end else if (wrStrobe && paddr == rcc_pkg::OFS_CAUSE) begin
         resetCause <= pwdata[rcc_pkg::CAUSE_W-1:0];
      end
   end

   // ==========================================================
   // Write data fields for the clock configuration register
   assign wrSysDiv       = pwdata[rcc_pkg::SYSTEM_CLOCK_DIVISOR_LSB +: rcc_pkg::SYSTEM_CLOCK_DIVISOR_W];
   assign wrBypass       = pwdata[rcc_pkg::BYPASS_BIT];
   assign wrSysDivEnable = pwdata[rcc_pkg::SYSTEM_CLOCK_DIVISOR_EN_BIT];

   // ==========================================================
   // Clock configuration register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         autoGating   <= rcc_pkg::AUTO_GATING_RST;
         sysDivisor   <= rcc_pkg::SYSTEM_CLOCK_DIVISOR_RST;
         sysDivEnable <= rcc_pkg::SYSTEM_CLOCK_DIVISOR_EN_RST;
         pwmDivEnable <= rcc_pkg::PWM_CLOCK_DIVISOR_EN_RST;
         pwmDivisor   <= rcc_pkg::PWM_CLOCK_DIVISOR_RST;
         bypass       <= rcc_pkg::BYPASS_RST;
      end else if (wrStrobe && paddr == rcc_pkg::OFS_CLKCFG) begin
         autoGating   <= pwdata[rcc_pkg::AUTO_GATING_BIT];
         sysDivisor   <= wrSysDiv;
         sysDivEnable <= wrSysDivEnable;
         pwmDivEnable <= pwdata[rcc_pkg::PWM_CLOCK_DIVISOR_EN_BIT];
         pwmDivisor   <= pwdata[rcc_pkg::PWM_CLOCK_DIVISOR_LSB +: rcc_pkg::PWM_CLOCK_DIVISOR_W];
         bypass       <= wrBypass;
      end
   end

   // ==========================================================
   // Events: reserved divisor code written, divider forced on
   always_comb begin
      irqEvent = '0;
      if (wrStrobe && paddr == rcc_pkg::OFS_CLKCFG) begin
         irqEvent[rcc_pkg::IRQ_RESERVED_DIV] = (wrSysDiv == rcc_pkg::SYSTEM_CLOCK_DIVISOR_RESERVED) ||
            (!wrBypass && wrSysDiv < rcc_pkg::SYSTEM_CLOCK_DIVISOR_MIN_PLL);
         irqEvent[rcc_pkg::IRQ_FORCED_DIV]   = !wrBypass && !wrSysDivEnable;
      end
   end

   // ==========================================================
   // Sticky status, write one to clear, set wins over clear
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irqStatus <= rcc_pkg::IRQ_RST;
      end else if (wrStrobe && paddr == rcc_pkg::OFS_IRQSTAT) begin
         irqStatus <= (irqStatus & ~pwdata[rcc_pkg::IRQ_W-1:0]) | irqEvent;
      end else begin
         irqStatus <= irqStatus | irqEvent;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irqMask <= rcc_pkg::IRQ_RST;
      end else if (wrStrobe && paddr == rcc_pkg::OFS_IRQMASK) begin
         irqMask <= pwdata[rcc_pkg::IRQ_W-1:0];
      end
   end

   // Level interrupt
   assign irq = |(irqStatus & irqMask);

   // ==========================================================
   // Read data, captured in the setup cycle
   always_comb begin
      clkCfgValue = '0;
      clkCfgValue[rcc_pkg::AUTO_GATING_BIT]                   = autoGating;
      clkCfgValue[rcc_pkg::SYSTEM_CLOCK_DIVISOR_LSB +: rcc_pkg::SYSTEM_CLOCK_DIVISOR_W]   = sysDivisor;
      clkCfgValue[rcc_pkg::SYSTEM_CLOCK_DIVISOR_EN_BIT]                     = sysDivEnable;
      clkCfgValue[rcc_pkg::PWM_CLOCK_DIVISOR_EN_BIT]                     = pwmDivEnable;
      clkCfgValue[rcc_pkg::PWM_CLOCK_DIVISOR_LSB +: rcc_pkg::PWM_CLOCK_DIVISOR_W]   = pwmDivisor;
      clkCfgValue[rcc_pkg::BYPASS_BIT]                        = bypass;
      case (paddr)
         rcc_pkg::OFS_CAUSE:   readValue = {26'h0, resetCause};
         rcc_pkg::OFS_CLKCFG:  readValue = clkCfgValue;
         rcc_pkg::OFS_IRQSTAT: readValue = {30'h0, irqStatus};
         rcc_pkg::OFS_IRQMASK: readValue = {30'h0, irqMask};
         default:              readValue = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
      end else if (setupPhase) begin
         prdata <= readValue;
      end
   end

   // ==========================================================
   // Power mode from the sleep requests
   always_comb begin
      if (deepSleepReq) begin
         next_powerMode = rcc_pkg::MODE_DEEP;
      end else if (sleepReq) begin
         next_powerMode = rcc_pkg::MODE_SLEEP;
      end else begin
         next_powerMode = rcc_pkg::MODE_RUN;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         powerMode <= rcc_pkg::MODE_RUN;
      end else begin
         powerMode <= next_powerMode;
      end
   end

   // ==========================================================
   // Peripheral clock gating selection
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         periphClkEn <= '0;
      end else begin
         case (powerMode)
            rcc_pkg::MODE_RUN:   periphClkEn <= runGatingSet;
            rcc_pkg::MODE_SLEEP: periphClkEn <= autoGating ? sleepGatingSet
                                                           : runGatingSet;
            rcc_pkg::MODE_DEEP:  periphClkEn <= autoGating ? deepSleepGatingSet
                                                           : runGatingSet;
            default:             periphClkEn <= runGatingSet;
         endcase
      end
   end

   // ==========================================================
   // System divider: clamp under the PLL, force on without bypass
   assign effSysDiv  = (!bypass && sysDivisor < rcc_pkg::SYSTEM_CLOCK_DIVISOR_MIN_PLL) ?
                       rcc_pkg::SYSTEM_CLOCK_DIVISOR_MIN_PLL : sysDivisor;
   assign sysDivUsed = sysDivEnable || !bypass;
   assign sysSrcPll  = !bypass;

   assign system_clock_divisor.enable = sysDivUsed;
   assign system_clock_divisor.tick   = 1'b1;
   assign system_clock_divisor.ratio  = rcc_pkg::SYS_RATIO_W'({1'b0, effSysDiv} + 5'h01);
   assign sysClkEn      = system_clock_divisor.pulse;

   clk_pulse_div #(.W(rcc_pkg::SYS_RATIO_W)) u_sys_div (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .dv      (system_clock_divisor.div)
   );

   // ==========================================================
   // PWM divider counts system enables, power of two ratios
   assign pwmCode       = (pwmDivisor > rcc_pkg::PWM_CLOCK_DIVISOR_TOP_CODE) ?
                          rcc_pkg::PWM_CLOCK_DIVISOR_TOP_CODE : pwmDivisor;
   assign pwm_clock_divisor.enable = pwmDivEnable;
   assign pwm_clock_divisor.tick   = sysClkEn;
   assign pwm_clock_divisor.ratio  = 7'h02 << pwmCode;
   assign pwmClkEn      = pwm_clock_divisor.pulse;

   clk_pulse_div #(.W(rcc_pkg::PWM_RATIO_W)) u_pwm_div (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .dv      (pwm_clock_divisor.div)
   );

   // ==========================================================
   // Checks
   property p_pin_clears;
      @(posedge clk_sys) (!nrst && causeSync[rcc_pkg::CAUSE_OUTSIDE_PIN])
         |=> resetCause == rcc_pkg::CAUSE_ONLY_PIN;
   endproperty
   a_pin_clears: assert property (p_pin_clears) else $error("pin reset left flags");

   property p_cause_loaded;
      @(posedge clk_sys) (!nrst && !causeSync[rcc_pkg::CAUSE_OUTSIDE_PIN])
         |=> (resetCause & $past(causeSync)) == $past(causeSync);
   endproperty
   a_cause_loaded: assert property (p_cause_loaded) else $error("cause not set");

   property p_sticky;
      @(posedge clk_sys) (!nrst && !causeSync[rcc_pkg::CAUSE_OUTSIDE_PIN])
         |=> (resetCause & $past(resetCause)) == $past(resetCause);
   endproperty
   a_sticky: assert property (p_sticky) else $error("cause flag lost");

   property p_cause_write;
      @(posedge clk_sys) disable iff (!nrst)
         (wrStrobe && paddr == rcc_pkg::OFS_CAUSE)
         |=> resetCause == $past(pwdata[rcc_pkg::CAUSE_W-1:0]);
   endproperty
   a_cause_write: assert property (p_cause_write) else $error("cause write lost");

   property p_auto_gating;
      @(posedge clk_sys) disable iff (!nrst)
         (autoGating && powerMode == rcc_pkg::MODE_DEEP)
         |=> periphClkEn == $past(deepSleepGatingSet);
   endproperty
   a_auto_gating: assert property (p_auto_gating) else $error("deep set unused");

   property p_no_auto;
      @(posedge clk_sys) disable iff (!nrst)
         (!autoGating && powerMode != rcc_pkg::MODE_RUN)
         |=> periphClkEn == $past(runGatingSet);
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("run set not kept");

   property p_run_mode;
      @(posedge clk_sys) disable iff (!nrst)
         (powerMode == rcc_pkg::MODE_RUN) |=> periphClkEn == $past(runGatingSet);
   endproperty
   a_run_mode: assert property (p_run_mode) else $error("run mode gating wrong");

   property p_pll_limit;
      @(posedge clk_sys) disable iff (!nrst)
         !bypass |-> (effSysDiv >= rcc_pkg::SYSTEM_CLOCK_DIVISOR_MIN_PLL) && sysDivUsed && sysSrcPll;
   endproperty
   a_pll_limit: assert property (p_pll_limit) else $error("pll divider wrong");

   property p_pwm_bypass;
      @(posedge clk_sys) disable iff (!nrst)
         (!pwmDivEnable && !$past(pwmDivEnable)) |-> pwmClkEn == $past(sysClkEn);
   endproperty
   a_pwm_bypass: assert property (p_pwm_bypass) else $error("pwm divider used");

   property p_sys_spacing;
      @(posedge clk_sys) disable iff (!nrst)
         (sysDivUsed && sysClkEn && effSysDiv == 4'h3 && $stable(effSysDiv))
         |=> !sysClkEn [*3];
   endproperty
   a_sys_spacing: assert property (p_sys_spacing) else $error("sys pulse early");

   // An event must survive a clear written in the same cycle
   property p_status_set_wins;
      @(posedge clk_sys) disable iff (!nrst)
         (irqEvent != '0) |=> (irqStatus & $past(irqEvent)) == $past(irqEvent);
   endproperty
   a_status_set_wins: assert property (p_status_set_wins) else $error("event lost to clear");

   // Reserved divisor code raises its status bit
   property p_reserved_code;
      @(posedge clk_sys) disable iff (!nrst)
         (wrStrobe && paddr == rcc_pkg::OFS_CLKCFG && wrSysDiv == rcc_pkg::SYSTEM_CLOCK_DIVISOR_RESERVED)
         |=> irqStatus[rcc_pkg::IRQ_RESERVED_DIV];
   endproperty
   a_reserved_code: assert property (p_reserved_code) else $error("code 0 unflagged");

endmodule

// File: sim/reset_cause_and_clock_config_tb_top.sv
// Self-checking testbench for the reset-cause and run-clock configuration block
`timescale 1ns/1ps
module reset_cause_and_clock_config_tb_top;
   // ==========================================================
   // Stimulus and observed signals
   logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0]  resetSource;
   logic        sleepReq, deepSleepReq, sysClkEn, pwmClkEn, sysSrcPll;
   logic [31:0] runGatingSet, sleepGatingSet, deepSleepGatingSet, periphClkEn;
   int          failures, checks;

   reset_cause_clock_ctrl dut_u (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .resetSource(resetSource), .sleepReq(sleepReq),
      .deepSleepReq(deepSleepReq), .runGatingSet(runGatingSet),
      .sleepGatingSet(sleepGatingSet), .deepSleepGatingSet(deepSleepGatingSet),
      .periphClkEn(periphClkEn), .sysClkEn(sysClkEn), .pwmClkEn(pwmClkEn),
      .sysSrcPll(sysSrcPll), .irq(irq));

   // ==========================================================
   // Clock, 40 ns period
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ==========================================================
   // Comparison and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Clock configuration word from its fields
   function automatic logic [31:0] cfg(input logic auto_gating_select, input logic [3:0] sd, input logic en,
                                       input logic pe, input logic [2:0] pd, input logic byp);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[rcc_pkg::AUTO_GATING_BIT] = auto_gating_select;
      v[rcc_pkg::SYSTEM_CLOCK_DIVISOR_LSB +: rcc_pkg::SYSTEM_CLOCK_DIVISOR_W] = sd;
      v[rcc_pkg::SYSTEM_CLOCK_DIVISOR_EN_BIT] = en;
      v[rcc_pkg::PWM_CLOCK_DIVISOR_EN_BIT] = pe;
      v[rcc_pkg::PWM_CLOCK_DIVISOR_LSB +: rcc_pkg::PWM_CLOCK_DIVISOR_W] = pd;
      v[rcc_pkg::BYPASS_BIT] = byp;
      return v;
   endfunction

   // ==========================================================
   // APB master: setup, access held until pready, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(r, exp);
      check({31'h0, e}, 32'h0000_0000);
   endtask

   // Reset held ten cycles with the given cause lines
   task automatic doReset(input logic [5:0] src);
      @(posedge clk_sys);
      nrst <= 1'b0; resetSource <= src;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1; resetSource <= 6'h00;
   endtask

   // Cycles between two enable pulses, after skipping two pulses
   task automatic period(input logic pwm, output int n);
      int k;
      k = 0;
      repeat (2) begin
         do begin
            @(posedge clk_sys);
            k++;
         end while ((pwm ? pwmClkEn : sysClkEn) !== 1'b1 && k < 1000);
      end
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while ((pwm ? pwmClkEn : sysClkEn) !== 1'b1 && n < 1000);
   endtask

   // ==========================================================
   // Scenarios
   task automatic tRstCause;
      doReset(6'h01);
      rdChk(rcc_pkg::OFS_CAUSE, 32'h0000_0001);
      doReset(6'h08);
      rdChk(rcc_pkg::OFS_CAUSE, 32'h0000_0009);
      doReset(6'h36);
      rdChk(rcc_pkg::OFS_CAUSE, 32'h0000_003F);
      doReset(6'h09);
      rdChk(rcc_pkg::OFS_CAUSE, 32'h0000_0001);
      doReset(6'h04);
      rdChk(rcc_pkg::OFS_CAUSE, 32'h0000_0005);
      wr(rcc_pkg::OFS_CAUSE, 32'hFFFF_FFFF);
      rdChk(rcc_pkg::OFS_CAUSE, 32'h0000_003F);
      wr(rcc_pkg::OFS_CAUSE, 32'h0000_0000);
      rdChk(rcc_pkg::OFS_CAUSE, 32'h0000_0000);
   endtask

   task automatic tCfgRegs;
      logic [31:0] r;
      logic        e;
      rdChk(rcc_pkg::OFS_CLKCFG, cfg(0, 4'hF, 0, 0, 3'h7, 1));
      check({31'h0, sysSrcPll}, 32'h0000_0000);
      check({31'h0, sysClkEn}, 32'h0000_0001);
      wr(rcc_pkg::OFS_CLKCFG, 32'hFFFF_FFFF);
      rdChk(rcc_pkg::OFS_CLKCFG, cfg(1, 4'hF, 1, 1, 3'h7, 1));
      apb(1'b1, 12'h100, 32'hFFFF_FFFF, r, e);
      check({31'h0, e}, 32'h0000_0001);
      apb(1'b0, 12'h100, 32'h0000_0000, r, e);
      check(r, 32'h0000_0000);
   endtask

   task automatic tGating;
      runGatingSet <= 32'hA5A5_0001; sleepGatingSet <= 32'h0F0F_0002;
      deepSleepGatingSet <= 32'h3333_0004;
      wr(rcc_pkg::OFS_CLKCFG, cfg(0, 4'hF, 0, 0, 3'h7, 1));
      sleepReq <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(periphClkEn, 32'hA5A5_0001);
      sleepReq <= 1'b0;
      wr(rcc_pkg::OFS_CLKCFG, cfg(1, 4'hF, 0, 0, 3'h7, 1));
      repeat (4) @(posedge clk_sys);
      check(periphClkEn, 32'hA5A5_0001);
      sleepReq <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(periphClkEn, 32'h0F0F_0002);
      deepSleepReq <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(periphClkEn, 32'h3333_0004);
      sleepReq <= 1'b0; deepSleepReq <= 1'b0;
   endtask

   task automatic tDividers;
      int n;
      wr(rcc_pkg::OFS_CLKCFG, cfg(0, 4'h3, 1, 0, 3'h7, 1));
      period(1'b0, n);
      check(n, 4);
      period(1'b1, n);
      check(n, 4);
      wr(rcc_pkg::OFS_CLKCFG, cfg(0, 4'h1, 1, 0, 3'h7, 0));
      period(1'b0, n);
      check(n, 4);
      check({31'h0, sysSrcPll}, 32'h0000_0001);
      for (int c = 0; c < 8; c++) begin
         wr(rcc_pkg::OFS_CLKCFG, cfg(0, 4'h1, 1, 1, c[2:0], 1));
         period(1'b1, n);
         check(n, 2 * (2 << ((c > 5) ? 5 : c)));
      end
      wr(rcc_pkg::OFS_IRQSTAT, 32'h0000_0003);
   endtask

   task automatic tIrq;
      rdChk(rcc_pkg::OFS_IRQSTAT, 32'h0000_0000);
      wr(rcc_pkg::OFS_CLKCFG, cfg(0, 4'h1, 0, 0, 3'h7, 0));
      rdChk(rcc_pkg::OFS_IRQSTAT, 32'h0000_0003);
      check({31'h0, irq}, 32'h0000_0000);
      wr(rcc_pkg::OFS_IRQMASK, 32'h0000_0001);
      @(posedge clk_sys);
      check({31'h0, irq}, 32'h0000_0001);
      wr(rcc_pkg::OFS_IRQSTAT, 32'h0000_0001);
      rdChk(rcc_pkg::OFS_IRQSTAT, 32'h0000_0002);
      check({31'h0, irq}, 32'h0000_0000);
      wr(rcc_pkg::OFS_IRQMASK, 32'h0000_0002);
      @(posedge clk_sys);
      check({31'h0, irq}, 32'h0000_0001);
      wr(rcc_pkg::OFS_IRQSTAT, 32'h0000_0002);
      @(posedge clk_sys);
      check({31'h0, irq}, 32'h0000_0000);
      wr(rcc_pkg::OFS_CLKCFG, cfg(0, 4'h0, 1, 0, 3'h7, 1));
      rdChk(rcc_pkg::OFS_IRQSTAT, 32'h0000_0001);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      failures = 0; checks = 0;
      nrst = 1'b0; resetSource = 6'h01; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000; sleepReq = 1'b0; deepSleepReq = 1'b0;
      runGatingSet = 32'h0000_0000; sleepGatingSet = 32'h0000_0000;
      deepSleepGatingSet = 32'h0000_0000;
      tRstCause();
      tCfgRegs();
      tGating();
      tDividers();
      tIrq();
      end_sim();
   end

   // Watchdog against a hang
   initial begin
      #800000;
      failures++;
      end_sim();
   end
endmodule
